// ---- dpol_pkg.sv ----
// Purpose: Shared constants, field layout and helpers for the dead-band and output logic
// Assumes: APB word registers, byte address is four times the register index
// Notes: All registers reset to zero, so every pin starts in high impedance
package dpol_pkg;

   // Bus geometry and unit/pin counts
   localparam int ADDR_W = 18;
   localparam int NUM_FULL = 3;
   localparam int NUM_UNITS = 6;
   localparam int NUM_PINS = 9;

   // Register indices (byte address = index * 4)
   localparam logic [15:0] IDX_SACT = 16'h7414;
   localparam logic [15:0] IDX_DBTC = 16'h7415;
   localparam logic [15:0] IDX_COMCTL = 16'h7420;
   localparam logic [15:0] IDX_FACT = 16'h7421;
   localparam logic [15:0] IDX_CMP0 = 16'h7422;
   localparam logic [15:0] IDX_ISTAT = 16'h7428;
   localparam logic [15:0] IDX_IMASK = 16'h7429;
   localparam logic [15:0] IDX_STATE = 16'h742a;

   // Reset value of every register
   localparam logic [15:0] RST_REG = 16'h0000;

   // Compare control fields
   localparam int CC_FMODE = 0;
   localparam int CC_SMODE = 3;
   localparam int CC_SOE = 8;
   localparam int CC_FOE = 9;
   localparam int CC_STSEL = 10;
   localparam int CC_PDPEN = 13;
   localparam int CC_CEN = 15;

   // Dead-band control fields
   localparam int DB_PS = 3;
   localparam int DB_EN = 5;
   localparam int DB_PER = 8;
   localparam logic [2:0] DB_RSVD = 3'h0;

   // Interrupt status layout: bits 5..0 unit matches, bit 6 protect trip
   localparam int EV_W = 7;
   localparam int EV_TRIP = 6;

   // PWM-mode action codes
   localparam logic [1:0] ACT_FLO = 2'h0;
   localparam logic [1:0] ACT_ALO = 2'h1;
   localparam logic [1:0] ACT_AHI = 2'h2;
   localparam logic [1:0] ACT_FHI = 2'h3;

   // Compare-mode action codes
   localparam logic [1:0] CMP_HOLD = 2'h0;
   localparam logic [1:0] CMP_SET = 2'h1;
   localparam logic [1:0] CMP_RST = 2'h2;
   localparam logic [1:0] CMP_TGL = 2'h3;

   // Dead-band configuration as seen by the pair generators
   typedef struct packed {
      logic [7:0] period;
      logic [2:0] enable;
      logic [1:0] prescale;
   } dpol_db_s;

   // PWM-mode output level from action code and waveform value
   function automatic logic act_pwm(input logic [1:0] a, input logic v);
      case (a)
         ACT_FLO: act_pwm = 1'b0;
         ACT_ALO: act_pwm = ~v;
         ACT_AHI: act_pwm = v;
         default: act_pwm = 1'b1;
      endcase
   endfunction

   // Compare-mode level after a match
   function automatic logic act_cmp(input logic [1:0] a, input logic cur);
      case (a)
         CMP_HOLD: act_cmp = cur;
         CMP_SET: act_cmp = 1'b1;
         CMP_RST: act_cmp = 1'b0;
         default: act_cmp = ~cur;
      endcase
   endfunction

endpackage

// ---- dpol_deadband.sv ----
// Purpose: One complementary pair generator with programmable dead band
// Assumes: Phase input changes on clock edges only
// Notes: High side rises late, low side falls late, both are turned off at once
`timescale 1ns/100ps
module dpol_deadband import dpol_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic enable,
   input wire logic [1:0] prescale,
   input wire logic [7:0] period,
   // Phase in, pair out
   input wire logic phase,
   output logic dt_high,
   output logic dt_low
);
   logic ph_q;
   logic [7:0] cnt;
   logic [2:0] pre;
   logic [2:0] pre_mask;
   logic chg;
   logic tick;
   logic done;

   // Divisor 1, 2, 4 or 8 of the clock
   assign pre_mask = (3'h1 << prescale) - 3'h1;
   assign tick = (pre & pre_mask) == pre_mask;
   assign chg = phase != ph_q;
   // Turn-on is allowed on the edge that empties the counter, so the gap is exact
   assign done = chg ? period == 8'h00 : (cnt == 8'h00 || (cnt == 8'h01 && tick));

   // Previous phase for edge detection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_q <= 1'b0;
      end else begin
         ph_q <= phase;
      end
   end

   // Prescaler restarts at each edge so the gap is exactly period times divisor
   always_ff @(posedge clk) begin
      if (!rst_n || chg) begin
         pre <= 3'h0;
      end else begin
         pre <= pre + 3'h1;
      end
   end

   // Down counter reloaded on every phase edge; an edge before zero restarts it
   always_ff @(posedge clk) begin
      if (!rst_n || !enable) begin
         cnt <= 8'h00;
      end else if (chg) begin
         cnt <= period;
      end else if (tick && cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end

   // Pair outputs; a pulse shorter than the gap never turns the high side on
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dt_high <= 1'b0;
         dt_low <= 1'b0;
      end else if (!enable) begin
         dt_high <= phase;
         dt_low <= phase;
      end else begin
         dt_high <= phase & done;
         dt_low <= phase | ~done;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_db_no_overlap;
      enable && $past(enable) |-> !(dt_high && !dt_low);
   endproperty
   a_db_no_overlap: assert property (p_db_no_overlap) else $error("pair overlap");

   property p_db_turnoff;
      enable && ph_q && !phase |=> !dt_high ##1 !dt_high;
   endproperty
   a_db_turnoff: assert property (p_db_turnoff) else $error("high side late off");

   property p_db_reload;
      enable && chg |=> cnt == $past(period);
   endproperty
   a_db_reload: assert property (p_db_reload) else $error("gap not reloaded");

endmodule

// ---- dpol_top.sv ----
// Purpose: Compare, dead-band and output logic driving nine compare/PWM pins
// Assumes: Timer counts and period-end pulses are synchronous to SYS_CLK
// Notes: Protect input blanks the pin enables combinationally, without a clock
`timescale 1ns/100ps
module dpol_top import dpol_pkg::*; (
   // System
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Time bases
   input wire logic [15:0] TIMER1_CNT,
   input wire logic TIMER1_PERIOD_END,
   input wire logic [15:0] TIMER2_CNT,
   input wire logic TIMER2_PERIOD_END,
   // Protection
   input wire logic POWER_DRIVE_PROTECT_N,
   // Pins and interrupt
   output logic [NUM_PINS-1:0] PWM_CMP_OUT,
   output logic [NUM_PINS-1:0] PWM_CMP_OE,
   output logic IRQ
);
   // Registers
   logic [15:0] compare_control_reg;
   logic [11:0] full_action_ctrl;
   logic [5:0] simple_action_ctrl;
   logic [15:0] deadband_timer_ctrl;
   logic [15:0] compare_value_reg [0:NUM_UNITS-1];
   logic [EV_W-1:0] int_status;
   logic [EV_W-1:0] int_mask;

   // Bus decode
   logic [15:0] idx;
   logic mapped;
   logic wr;
   logic [31:0] rd_val;

   // Datapath
   dpol_db_s db_cfg;
   logic cen;
   logic trip;
   logic [NUM_UNITS-1:0] pwm_mode;
   logic [NUM_UNITS-1:0] eq;
   logic [NUM_UNITS-1:0] eq_q;
   logic [NUM_UNITS-1:0] match;
   logic [NUM_UNITS-1:0] per_end;
   logic [NUM_UNITS-1:0] waveform_phase;
   logic [NUM_FULL-1:0] db_on;
   logic [NUM_FULL-1:0] deadband_phase_high;
   logic [NUM_FULL-1:0] deadband_phase_low;
   logic [1:0] act [0:NUM_PINS-1];
   logic [NUM_PINS-1:0] pwm_val;
   logic [NUM_PINS-1:0] pin_mode;
   logic [NUM_PINS-1:0] pin_match;
   logic [NUM_PINS-1:0] cmp_state;
   logic [NUM_PINS-1:0] next_out;
   logic [NUM_PINS-1:0] oe_q;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] clr;

   // Address decode; register index is the word address
   assign idx = PADDR[ADDR_W-1:2];
   assign mapped = idx == IDX_SACT || idx == IDX_DBTC || idx == IDX_COMCTL
      || idx == IDX_FACT || idx == IDX_ISTAT || idx == IDX_IMASK
      || idx == IDX_STATE || (idx >= IDX_CMP0 && idx < IDX_CMP0 + 16'(NUM_UNITS));
   assign wr = PSEL && PENABLE && PWRITE && mapped;

   // Zero wait states; unmapped accesses answer with an error
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;

   // Control registers; reserved dead-band bits never store
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         compare_control_reg <= RST_REG;
         full_action_ctrl <= RST_REG[11:0];
         simple_action_ctrl <= RST_REG[5:0];
         deadband_timer_ctrl <= RST_REG;
         int_mask <= RST_REG[EV_W-1:0];
      end else if (wr) begin
         case (idx)
            IDX_COMCTL: compare_control_reg <= PWDATA[15:0];
            IDX_FACT: full_action_ctrl <= PWDATA[11:0];
            IDX_SACT: simple_action_ctrl <= PWDATA[5:0];
            IDX_DBTC: deadband_timer_ctrl <= {PWDATA[15:3], DB_RSVD};
            IDX_IMASK: int_mask <= PWDATA[EV_W-1:0];
            default: ;
         endcase
      end
   end

   // Compare values, one word per unit
   always_ff @(posedge SYS_CLK) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
         if (!RST_N) begin
            compare_value_reg[i] <= RST_REG;
         end else if (wr && idx == IDX_CMP0 + 16'(i)) begin
            compare_value_reg[i] <= PWDATA[15:0];
         end
      end
   end

   // Read mux; registered in the setup phase so data is steady in access
   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         IDX_COMCTL: rd_val = {16'h0000, compare_control_reg};
         IDX_FACT: rd_val = {20'h00000, full_action_ctrl};
         IDX_SACT: rd_val = {26'h0000000, simple_action_ctrl};
         IDX_DBTC: rd_val = {16'h0000, deadband_timer_ctrl};
         IDX_ISTAT: rd_val = {25'h0000000, int_status};
         IDX_IMASK: rd_val = {25'h0000000, int_mask};
         IDX_STATE: rd_val = {7'h00, trip, waveform_phase, PWM_CMP_OE, PWM_CMP_OUT};
         default: begin
            if (idx >= IDX_CMP0 && idx < IDX_CMP0 + 16'(NUM_UNITS)) begin
               rd_val = {16'h0000, compare_value_reg[3'(idx - IDX_CMP0)]};
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= rd_val;
      end
   end

   // Control views
   assign cen = compare_control_reg[CC_CEN];
   assign pwm_mode = {compare_control_reg[CC_SMODE +: 3], compare_control_reg[CC_FMODE +: 3]};
   assign db_cfg.period = deadband_timer_ctrl[DB_PER +: 8];
   assign db_cfg.enable = deadband_timer_ctrl[DB_EN +: 3];
   assign db_cfg.prescale = deadband_timer_ctrl[DB_PS +: 2];
   assign db_on = db_cfg.enable & pwm_mode[NUM_FULL-1:0];
   assign trip = compare_control_reg[CC_PDPEN] && !POWER_DRIVE_PROTECT_N;

   // Equality per unit; full units on timer 1, simple on the selected timer
   always_comb begin
      for (int i = 0; i < NUM_FULL; i++) begin
         eq[i] = TIMER1_CNT == compare_value_reg[i];
         per_end[i] = TIMER1_PERIOD_END;
         if (compare_control_reg[CC_STSEL + i]) begin
            eq[NUM_FULL + i] = TIMER2_CNT == compare_value_reg[NUM_FULL + i];
            per_end[NUM_FULL + i] = TIMER2_PERIOD_END;
         end else begin
            eq[NUM_FULL + i] = TIMER1_CNT == compare_value_reg[NUM_FULL + i];
            per_end[NUM_FULL + i] = TIMER1_PERIOD_END;
         end
      end
   end

   // A match is the first cycle of equality, so a slow timer gives one event
   assign match = eq & ~eq_q & {NUM_UNITS{cen}};

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         eq_q <= '0;
      end else begin
         eq_q <= eq;
      end
   end

   // Waveform phases: toggle on match, back to inactive at period end unless the unit's dead band is on
   always_ff @(posedge SYS_CLK) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
         if (!RST_N || !cen) begin
            waveform_phase[i] <= 1'b0;
         end else if (match[i]) begin
            waveform_phase[i] <= ~waveform_phase[i];
         end else if (per_end[i] && !(i < NUM_FULL && db_on[i])) begin
            waveform_phase[i] <= 1'b0;
         end
      end
   end

   // One pair generator per full unit
   for (genvar u = 0; u < NUM_FULL; u++) begin : g_db
      dpol_deadband u_db (
         .clk(SYS_CLK),
         .rst_n(RST_N),
         .enable(db_on[u]),
         .prescale(db_cfg.prescale),
         .period(db_cfg.period),
         .phase(waveform_phase[u]),
         .dt_high(deadband_phase_high[u]),
         .dt_low(deadband_phase_low[u])
      );
   end

   // Per-pin source, action, mode and match: six full pins then three simple
   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         if (p < 2 * NUM_FULL) begin
            act[p] = full_action_ctrl[2*p +: 2];
            pwm_val[p] = p[0] ? deadband_phase_low[p/2] : deadband_phase_high[p/2];
            pin_mode[p] = pwm_mode[p/2];
            pin_match[p] = match[p/2];
         end else begin
            act[p] = simple_action_ctrl[2*(p-6) +: 2];
            pwm_val[p] = waveform_phase[p-3];
            pin_mode[p] = pwm_mode[p-3];
            pin_match[p] = match[p-3];
         end
      end
   end

   // Compare-mode levels change only on a match of the pin's unit
   always_ff @(posedge SYS_CLK) begin
      for (int p = 0; p < NUM_PINS; p++) begin
         if (!RST_N) begin
            cmp_state[p] <= 1'b0;
         end else if (pin_match[p]) begin
            cmp_state[p] <= act_cmp(act[p], cmp_state[p]);
         end
      end
   end

   // Pin level: polarity in PWM mode, action state in compare mode
   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         next_out[p] = pin_mode[p] ? act_pwm(act[p], pwm_val[p]) : cmp_state[p];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         PWM_CMP_OUT <= '0;
      end else begin
         PWM_CMP_OUT <= next_out;
      end
   end

   // Pin enables: bit 9 for full pins, bit 8 for simple pins
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         oe_q <= '0;
      end else begin
         oe_q <= {{3{compare_control_reg[CC_SOE]}}, {6{compare_control_reg[CC_FOE]}}};
      end
   end

   // Protect is not clocked here so a fault cuts the drivers at once
   assign PWM_CMP_OE = trip ? '0 : oe_q;

   // Sticky events; a new event beats a clear in the same cycle
   assign events = {trip, match};
   assign clr = (wr && idx == IDX_ISTAT) ? PWDATA[EV_W-1:0] : '0;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         int_status <= '0;
      end else begin
         int_status <= (int_status & ~clr) | events;
      end
   end

   // Level interrupt
   assign IRQ = |(int_status & int_mask);

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   property p_oe_off;
      !compare_control_reg[CC_FOE] && !compare_control_reg[CC_SOE] |=> PWM_CMP_OE == '0;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pins driven while disabled");

   property p_trip;
      compare_control_reg[CC_PDPEN] && !POWER_DRIVE_PROTECT_N
         |-> PWM_CMP_OE == '0 ##1 int_status[EV_TRIP];
   endproperty
   a_trip: assert property (p_trip) else $error("protect did not blank pins");

   property p_reset_hiz;
      RST_N && !$past(RST_N) |-> PWM_CMP_OE == '0 && PWM_CMP_OUT == '0;
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("pins live after reset");

   property p_match_toggle;
      match[0] |=> waveform_phase[0] != $past(waveform_phase[0]);
   endproperty
   a_match_toggle: assert property (p_match_toggle) else $error("no transition on match");

   property p_period_clear;
      cen && per_end[3] && !match[3] |=> !waveform_phase[3];
   endproperty
   a_period_clear: assert property (p_period_clear) else $error("phase kept at period end");

   property p_db_keep;
      TIMER1_PERIOD_END && db_on[0] && !match[0] && cen
         |=> waveform_phase[0] == $past(waveform_phase[0]);
   endproperty
   a_db_keep: assert property (p_db_keep) else $error("pair forced at period end");

   property p_bypass;
      !pwm_mode[0] ##1 !pwm_mode[0]
         |-> deadband_phase_high[0] == $past(waveform_phase[0])
         && deadband_phase_low[0] == $past(waveform_phase[0]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("gap in compare mode");

   property p_act_high;
      pin_mode[6] && act[6] == ACT_AHI |=> PWM_CMP_OUT[6] == $past(waveform_phase[3]);
   endproperty
   a_act_high: assert property (p_act_high) else $error("active high wrong");

   property p_forced;
      pin_mode[0] && act[0][1] == act[0][0]
         |=> PWM_CMP_OUT[0] == $past(act[0][0]);
   endproperty
   a_forced: assert property (p_forced) else $error("forced level wrong");

   property p_cmp_set;
      !pin_mode[0] && pin_match[0] && act[0] == CMP_SET && !$past(pin_match[0])
         |=> cmp_state[0] ##1 PWM_CMP_OUT[0];
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("set on match failed");

endmodule

// ---- dpol_gate_model.sv ----
// Purpose: Gate-driver model for the three inverter legs
// Assumes: A high gate input turns its transistor on
// Notes: Undriven gates are pulled low by the driver board, so high-Z means off
`timescale 1ns/100ps
module dpol_gate_model import dpol_pkg::*; (
   // Clock
   input wire logic clk,
   // Pins from the block
   input wire logic [NUM_PINS-1:0] pins,
   input wire logic [NUM_PINS-1:0] oe,
   // Observations
   output int overlaps,
   output int gap [NUM_FULL]
);
   logic [5:0] gate;
   logic [5:0] gate_q = '0;
   int now = 0;
   int off_t [6];
   // Pull-down wins whenever the enable is low
   assign gate = pins[5:0] & oe[5:0];
   // Falls first, so a same-edge swap reads as a zero gap
   always @(posedge clk) begin
      for (int i = 0; i < 6; i++)
         if (gate_q[i] && !gate[i]) off_t[i] = now;
      for (int i = 0; i < 6; i++) begin
         if (!gate_q[i] && gate[i]) gap[i/2] = now - off_t[i^1];
         if (i[0] && gate[i] && gate[i-1]) overlaps++;
      end
      gate_q = gate;
      now++;
   end
endmodule

// ---- dpol_bench.sv ----
// Purpose: Self-checking bench for the dead-band and output logic
// Assumes: Zero-wait APB slave, gate drivers on the six full pins
// Notes: Gap settings come from a fixed seed beside two corner cases
`timescale 1ns/100ps
module dpol_bench import dpol_pkg::*; ;
   logic clk, rst_n, psel, penable, pwrite, t1e, t2e, prot_n, pready, perr, err, irq, ph, cur;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] t1c, t2c;
   logic [1:0] c;
   logic [NUM_PINS-1:0] pins, oe;
   logic [15:0] regs [8] = '{IDX_SACT, IDX_DBTC, IDX_COMCTL, IDX_FACT, IDX_CMP0, IDX_ISTAT,
      IDX_IMASK, IDX_STATE};
   logic [1:0] codes [6] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h3, 2'h0};
   int miscompares, compares, seed, ovl, m, ps, en, g, u;
   int gap [NUM_FULL];

   dpol_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(perr), .TIMER1_CNT(t1c), .TIMER1_PERIOD_END(t1e), .TIMER2_CNT(t2c),
      .TIMER2_PERIOD_END(t2e), .POWER_DRIVE_PROTECT_N(prot_n), .PWM_CMP_OUT(pins),
      .PWM_CMP_OE(oe), .IRQ(irq));
   dpol_gate_model u_gates (.clk(clk), .pins(pins), .oe(oe), .overlaps(ovl), .gap(gap));

   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic finish_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One APB transfer; the wait for ready is bounded so a dead slave ends the run
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) begin
         miscompares++;
         finish_test();
      end
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Counter sits on the compare value for one cycle of the chosen timer
   task automatic hit(input logic [15:0] v, input logic sel);
      if (sel) t2c <= v;
      else t1c <= v;
      @(posedge clk);
      t1c <= 16'hffff;
      t2c <= 16'hffff;
      @(posedge clk);
   endtask

   task automatic pend(input logic sel);
      if (sel) t2e <= 1'b1;
      else t1e <= 1'b1;
      @(posedge clk);
      t1e <= 1'b0;
      t2e <= 1'b0;
   endtask

   // Expected PWM-mode level for an action code and waveform value
   function automatic logic lvl(input logic [1:0] a, input logic v);
      return a[1] ? (a[0] | v) : (a[0] & ~v);
   endfunction

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      finish_test();
   end

   // Main sequence
   initial begin
      seed = 32'ha605;
      {rst_n, psel, penable, pwrite, t1e, t2e} = '0;
      prot_n = 1'b1;
      paddr = '0;
      pwdata = '0;
      t1c = 16'hffff;
      t2c = 16'hffff;
      tick(5);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (regs[i]) begin
         apb(1'b0, regs[i], '0);
         chk(rd, '0);
      end
      chk(oe, '0);
      apb(1'b0, 16'h7430, '0);
      chk(err, 1'b1);
      chk(rd, '0);
      apb(1'b1, IDX_DBTC, 32'hffff);
      apb(1'b0, IDX_DBTC, '0);
      chk(rd, 32'hfff8);
      $display("test registers done");
      // Simple unit 1 under every action code, time base alternating
      apb(1'b1, IDX_CMP0 + 16'h3, 32'h40);
      for (int k = 0; k < 4; k++) begin
         c = k[1:0];
         apb(1'b1, IDX_SACT, {30'h0, c});
         apb(1'b1, IDX_COMCTL, 32'h8108 | (k[0] << 10));
         hit(16'h40, c[0]);
         tick(2);
         chk(pins[6], lvl(c, 1'b1));
         chk(oe, 9'h1c0);
         pend(c[0]);
         tick(3);
         chk(pins[6], lvl(c, 1'b0));
      end
      $display("test simple done");
      // Each pair through two phase edges; the lower gate rises late, the upper too
      apb(1'b1, IDX_FACT, 32'h666);
      apb(1'b1, IDX_COMCTL, 32'h8207);
      for (int k = 0; k < 6; k++) begin
         u = k % 3;
         m = (k == 0) ? 255 : (k == 1) ? 0 : $random(seed) & 15;
         ps = (k == 0) ? 3 : $random(seed) & 3;
         en = (k < 2) ? 1 : $random(seed) & 1;
         g = en ? m << ps : 0;
         apb(1'b1, IDX_DBTC, (m << 8) | (en << (5 + u)) | (ps << 3));
         apb(1'b1, IDX_CMP0 + 16'(u), 32'h20 + u);
         hit(16'h20 + 16'(u), 1'b0);
         tick(4 + g);
         chk(gap[u], g);
         chk(pins[2*u +: 2], 2'b01);
         pend(1'b0);
         tick(4);
         ph = en[0];
         chk(pins[2*u +: 2], ph ? 2'b01 : 2'b10);
         hit(16'h20 + 16'(u), 1'b0);
         tick(4 + g);
         chk(gap[u], g);
         chk(pins[2*u +: 2], ph ? 2'b10 : 2'b01);
      end
      // Forced levels on the upper pin of unit 1
      apb(1'b1, IDX_FACT, 32'h3);
      tick(1);
      chk(pins[0], 1'b1);
      apb(1'b1, IDX_FACT, 32'h0);
      tick(1);
      chk(pins[0], 1'b0);
      $display("test deadband done");
      // Compare mode on unit 1 with a long gap programmed, which must not apply;
      // pins stay undriven since both carry the same code and would short the leg
      apb(1'b1, IDX_DBTC, 32'hff38);
      apb(1'b1, IDX_COMCTL, 32'h8006);
      cur = 1'b0;
      foreach (codes[i]) begin
         c = codes[i];
         apb(1'b1, IDX_FACT, {28'h0, c, c});
         hit(16'h20, 1'b0);
         tick(2);
         cur = c[0] ? (c[1] ? ~cur : 1'b1) : (c[1] ? 1'b0 : cur);
         chk(pins[1:0], {cur, cur});
      end
      chk(pins[1], pins[0]);
      $display("test compare done");
      // Pin enables against masked and unmasked protect, software and reset
      apb(1'b1, IDX_COMCTL, 32'h8307);
      prot_n <= 1'b0;
      tick(2);
      chk(oe, 9'h1ff);
      prot_n <= 1'b1;
      apb(1'b1, IDX_ISTAT, 32'h7f);
      apb(1'b1, IDX_IMASK, 32'h40);
      apb(1'b1, IDX_COMCTL, 32'ha307);
      tick(1);
      chk(irq, 1'b0);
      prot_n <= 1'b0;
      @(posedge clk);
      #1 chk(oe, '0);
      tick(2);
      chk(irq, 1'b1);
      apb(1'b1, IDX_IMASK, '0);
      tick(1);
      chk(irq, 1'b0);
      prot_n <= 1'b1;
      tick(2);
      chk(oe, 9'h1ff);
      apb(1'b1, IDX_ISTAT, 32'h40);
      apb(1'b0, IDX_ISTAT, '0);
      chk(rd[6], 1'b0);
      apb(1'b1, IDX_COMCTL, 32'h8000);
      tick(1);
      chk(oe, '0);
      apb(1'b1, IDX_COMCTL, 32'h8307);
      rst_n <= 1'b0;
      tick(2);
      chk(oe, '0);
      chk(pins, '0);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(ovl, 0);
      $display("test outputs done");
      finish_test();
   end
endmodule
